// file: rtl/dmr_pkg.sv
// Purpose: Shared constants for the mode register decoder block.
// Assumes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
// Notes:   Field positions are address-pin numbers inside the mode register word.
package dmr_pkg;
  // Synchronised pin bundle layout.
  localparam int PIN_W        = 23;
  localparam int PIN_CKE      = 22;
  localparam int PIN_TERM     = 21;
  localparam int PIN_CS_N     = 20;
  localparam int PIN_RAS_N    = 19;
  localparam int PIN_CAS_N    = 18;
  localparam int PIN_WE_N     = 17;
  localparam int PIN_BA_LSB   = 14;
  // Idle pin levels after reset: clock enable high, command pins deselected.
  localparam logic [PIN_W-1:0] PIN_IDLE = 23'h5E0000;
  // Mode register select codes on the bank pins.
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  // Mode register one fields, and the register zero DLL reset bit.
  localparam int M1_DLL_OFF   = 0;
  localparam int M1_DRV_LO    = 1;
  localparam int M1_DRV_HI    = 5;
  localparam int M1_TRM_B0    = 2;
  localparam int M1_TRM_B1    = 6;
  localparam int M1_TRM_B2    = 9;
  localparam int M1_AL_LSB    = 3;
  localparam int M1_WLEVEL    = 7;
  localparam int M1_STROBE    = 11;
  localparam int M1_OUT_OFF   = 12;
  localparam int M0_DLL_RST   = 8;
  // Mode register two fields.
  localparam int M2_PARTIAL_ARRAY_REFRESH_LSB  = 0;
  localparam int M2_CWL_LSB   = 3;
  localparam int M2_ASR       = 6;
  localparam int M2_SRT       = 7;
  localparam int M2_RTTWR_LSB = 9;
  localparam logic [4:0] CWL_BASE   = 5'h05;
  localparam logic [4:0] BURST_CLKS = 5'h04;
  // Cycle counts.
  localparam logic [9:0] LOCK_WAIT_CYC = 10'h200;
  localparam int         AL_DEPTH      = 16;
  // Register map.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MR1    = 8'h04;
  localparam logic [7:0] OFF_MR2    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_LAT    = 8'h10;
  localparam logic [3:0] RST_CL     = 4'h6;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  localparam int         ERR_N      = 6;
endpackage

// file: rtl/dmr_cmd_delay.sv
// Purpose: Holds a command strobe for a programmable number of cycles.
// Assumes: i_delay stays below DEPTH.
// Notes:   A delay of zero passes the strobe straight through.
`timescale 1ns/1ps
`default_nettype none
module dmr_cmd_delay #(
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Strobe in and out.
  input  wire logic       i_cmd,
  input  wire logic [3:0] i_delay,
  output logic            o_cmd
);
  logic [DEPTH-1:0] pipe_reg;
  logic [3:0]       tap;

  assign tap   = 4'(i_delay - 4'h1);
  assign o_cmd = (i_delay == 4'h0) ? i_cmd : pipe_reg[tap];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= {pipe_reg[DEPTH-2:0], i_cmd};
    end
  end
endmodule
`default_nettype wire

// file: rtl/dmr_mode_regs.sv
// Purpose: Mode register one and two decode with latency, termination and refresh control.
// Assumes: Memory command pins arrive asynchronously and are synchronised here.
// Notes:   Software sets the read column latency and width option; errors are sticky, write one to clear.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - DLL drops in self-refresh, returns on exit
// - Write termination needs DLL running
// - Driver impedance from bits one and five
// - Write termination usable without nominal termination
// - Reads and writes held for posted delay
// - Posted delay zero, column minus one, two
// - Bit twelve disconnects data outputs
// - Mode set command pin pattern decode
// - Bit seven selects extended refresh range
// - Bit six enables automatic self-refresh
// - Partial refresh bank selection table
// - Unselected banks lost in self-refresh
// - Write termination encoding
// - Write column latency five to twelve
// - No write termination while leveling
// - Bit seven of register one enables leveling
module dmr_mode_regs
  import dmr_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // Memory command pins.
  input  wire logic        I_CKE,
  input  wire logic        I_TERM,
  input  wire logic        I_CS_N,
  input  wire logic        I_RAS_N,
  input  wire logic        I_CAS_N,
  input  wire logic        I_WE_N,
  input  wire logic [2:0]  I_BA,
  input  wire logic [13:0] I_A,
  // AXI4-Lite slave.
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  // Device controls.
  output logic             O_DLL_ON,
  output logic [1:0]       O_DRV_IMP,
  output logic             O_OUT_DISABLE,
  output logic             O_TERM_STROBE,
  output logic             O_WR_LEVEL,
  output logic             O_TERM_NOM_ON,
  output logic             O_TERM_WR_ON,
  output logic             O_RD_ISSUE,
  output logic             O_WR_ISSUE,
  output logic             O_SELF_REFRESH,
  output logic             O_SR_EXT_RANGE,
  output logic             O_AUTO_SR,
  output logic [7:0]       O_BANK_RETAIN
);
  logic [PIN_W-1:0]  sync1_reg, sync2_reg;
  logic [13:0]       mr1_reg, mr2_reg;
  logic              cke_prev_reg, sr_reg, locked_reg;
  logic [9:0]        lock_cnt_reg;
  logic [4:0]        wr_win_reg;
  logic [3:0]        cl_reg;
  logic              x16_reg;
  logic [ERR_N-1:0]  err_reg, err_set, err_next, err_clr;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg, rdata_reg;
  logic [3:0]        wstrb_reg;
  logic [1:0]        bresp_reg, rresp_reg;

  // Command decode on the synchronised pins.
  wire        cke     = sync2_reg[PIN_CKE];
  wire        term    = sync2_reg[PIN_TERM];
  wire        cs      = !sync2_reg[PIN_CS_N];
  wire        ras     = !sync2_reg[PIN_RAS_N];
  wire        cas     = !sync2_reg[PIN_CAS_N];
  wire        we      = !sync2_reg[PIN_WE_N];
  wire [2:0]  ba      = sync2_reg[PIN_BA_LSB +: 3];
  wire [13:0] addr    = sync2_reg[13:0];
  wire        cmd_mrs = cs & ras & cas & we;
  wire        cmd_ref = cs & ras & cas & !we;
  wire        cmd_rd  = cs & !ras & cas & !we;
  wire        cmd_wr  = cs & !ras & cas & we;
  wire        set_mr1 = cmd_mrs & (ba == BA_MR1);
  wire        set_mr2 = cmd_mrs & (ba == BA_MR2);
  wire        dll_rst = cmd_mrs & (ba == BA_MR0) & addr[M0_DLL_RST];
  wire        sr_entry = cmd_ref & cke_prev_reg & !cke;
  wire        sr_exit  = sr_reg & cke;
  wire        dll_on   = !mr1_reg[M1_DLL_OFF] & !sr_reg;
  wire        lock_run = dll_on & !locked_reg;

  wire [1:0]  al_code  = mr1_reg[M1_AL_LSB +: 2];
  wire [3:0]  al_val   = (al_code == 2'h1) ? 4'(cl_reg - 4'h1) :
                         (al_code == 2'h2) ? 4'(cl_reg - 4'h2) : 4'h0;
  wire [4:0]  write_column_latency      = 5'(CWL_BASE + {2'h0, mr2_reg[M2_CWL_LSB +: 3]});
  wire [4:0]  read_lat  = 5'({1'b0, al_val} + {1'b0, cl_reg});
  wire [4:0]  write_lat = 5'({1'b0, al_val} + write_column_latency);
  wire [2:0]  rtt_nom   = {mr1_reg[M1_TRM_B2], mr1_reg[M1_TRM_B1], mr1_reg[M1_TRM_B0]};
  wire [1:0]  rtt_wr    = mr2_reg[M2_RTTWR_LSB +: 2];
  // write termination needs DLL and no leveling
  wire        dyn_ok    = (rtt_wr != 2'h0) & dll_on & !mr1_reg[M1_WLEVEL];
  wire        wr_window = (wr_win_reg != 5'h0);
  wire        rd_int, wr_int;

  wire [2:0]  partial_array_refresh = mr2_reg[M2_PARTIAL_ARRAY_REFRESH_LSB +: 3];
  wire [7:0]  partial_array_refresh_mask = (partial_array_refresh == 3'h0) ? 8'hFF : (partial_array_refresh == 3'h1) ? 8'h0F :
                          (partial_array_refresh == 3'h2) ? 8'h03 : (partial_array_refresh == 3'h3) ? 8'h01 :
                          (partial_array_refresh == 3'h4) ? 8'hFC : (partial_array_refresh == 3'h5) ? 8'hF0 :
                          (partial_array_refresh == 3'h6) ? 8'hC0 : 8'h80;

  dmr_cmd_delay #(.DEPTH(AL_DEPTH)) u_rd_delay (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_cmd   (cmd_rd),
    .i_delay (al_val),
    .o_cmd   (rd_int)
  );
  dmr_cmd_delay #(.DEPTH(AL_DEPTH)) u_wr_delay (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_cmd   (cmd_wr),
    .i_delay (al_val),
    .o_cmd   (wr_int)
  );

  assign err_set = {
    (al_code == 2'h3) | (rtt_wr == 2'h3) | (rtt_nom[2:1] == 2'h3),
    x16_reg & mr1_reg[M1_STROBE],
    mr1_reg[M1_DLL_OFF] & (rtt_wr != 2'h0),
    mr1_reg[M1_DLL_OFF] & term & (rtt_nom != 3'h0),
    lock_run & !cke,
    lock_run & cmd_rd
  };
  wire wr_do = !awready_reg & !wready_reg & !bvalid_reg;
  wire wr_ok = (awaddr_reg == OFF_CTRL) | (awaddr_reg == OFF_STATUS);
  assign err_clr  = (wr_do & (awaddr_reg == OFF_STATUS) & wstrb_reg[1]) ? wdata_reg[8 +: ERR_N] : '0;
  // Set wins over a clear in the same cycle.
  assign err_next = (err_reg & ~err_clr) | err_set;

  wire [31:0] rd_mux =
    (I_ARADDR == OFF_CTRL)   ? {27'h0, x16_reg, cl_reg} :
    (I_ARADDR == OFF_MR1)    ? {18'h0, mr1_reg} :
    (I_ARADDR == OFF_MR2)    ? {18'h0, mr2_reg} :
    (I_ARADDR == OFF_STATUS) ? {18'h0, err_reg, 5'h0, sr_reg, locked_reg, dll_on} :
    (I_ARADDR == OFF_LAT)    ? {19'h0, write_lat, 3'h0, read_lat} : 32'h0;
  wire rd_ok = (I_ARADDR == OFF_CTRL) | (I_ARADDR == OFF_MR1) | (I_ARADDR == OFF_MR2) |
               (I_ARADDR == OFF_STATUS) | (I_ARADDR == OFF_LAT);

  // The pins are asynchronous to this clock, so two stages come first.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_reg <= PIN_IDLE;
      sync2_reg <= PIN_IDLE;
    end else begin
      sync1_reg <= {I_CKE, I_TERM, I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_BA, I_A};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mr1_reg <= '0;
      mr2_reg <= '0;
    end else begin
      if (set_mr1) begin
        mr1_reg <= addr;
      end
      if (set_mr2) begin
        mr2_reg <= addr;
      end
    end
  end

  // self-refresh state and lock wait counter
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cke_prev_reg <= 1'b0;
      sr_reg       <= 1'b0;
      lock_cnt_reg <= '0;
      locked_reg   <= 1'b0;
    end else begin
      cke_prev_reg <= cke;
      sr_reg       <= sr_entry | (sr_reg & !sr_exit);
      if (dll_rst | sr_exit) begin
        lock_cnt_reg <= '0;
        locked_reg   <= 1'b0;
      end else if (lock_run) begin
        lock_cnt_reg <= 10'(lock_cnt_reg + 10'h1);
        locked_reg   <= (lock_cnt_reg == 10'(LOCK_WAIT_CYC - 10'h1));
      end
    end
  end

  // write window covers column latency and the burst
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wr_win_reg <= '0;
    end else if (wr_int) begin
      wr_win_reg <= 5'(write_column_latency + BURST_CLKS);
    end else if (wr_window) begin
      wr_win_reg <= 5'(wr_win_reg - 5'h1);
    end
  end

  // Registered device controls.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_DLL_ON       <= 1'b0;
      O_DRV_IMP      <= '0;
      O_OUT_DISABLE  <= 1'b0;
      O_TERM_STROBE  <= 1'b0;
      O_WR_LEVEL     <= 1'b0;
      O_TERM_NOM_ON  <= 1'b0;
      O_TERM_WR_ON   <= 1'b0;
      O_RD_ISSUE     <= 1'b0;
      O_WR_ISSUE     <= 1'b0;
      O_SELF_REFRESH <= 1'b0;
      O_SR_EXT_RANGE <= 1'b0;
      O_AUTO_SR      <= 1'b0;
      O_BANK_RETAIN  <= 8'hFF;
    end else begin
      O_DLL_ON       <= dll_on;
      O_DRV_IMP      <= {mr1_reg[M1_DRV_HI], mr1_reg[M1_DRV_LO]};
      O_OUT_DISABLE  <= mr1_reg[M1_OUT_OFF];
      O_TERM_STROBE  <= mr1_reg[M1_STROBE] & !x16_reg;
      O_WR_LEVEL     <= mr1_reg[M1_WLEVEL];
      O_TERM_NOM_ON  <= term & (rtt_nom != 3'h0) & !(dyn_ok & wr_window);
      O_TERM_WR_ON   <= term & dyn_ok & wr_window;
      O_RD_ISSUE     <= rd_int;
      O_WR_ISSUE     <= wr_int;
      O_SELF_REFRESH <= sr_reg;
      O_SR_EXT_RANGE <= mr2_reg[M2_SRT];
      O_AUTO_SR      <= mr2_reg[M2_ASR];
      // banks outside the mask lose data
      O_BANK_RETAIN  <= sr_reg ? partial_array_refresh_mask : 8'hFF;
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      cl_reg      <= RST_CL;
      x16_reg     <= 1'b0;
      err_reg     <= '0;
    end else begin
      err_reg <= err_next;
      if (I_AWVALID & awready_reg) begin
        awaddr_reg  <= I_AWADDR;
        awready_reg <= 1'b0;
      end
      if (I_WVALID & wready_reg) begin
        wdata_reg  <= I_WDATA;
        wstrb_reg  <= I_WSTRB;
        wready_reg <= 1'b0;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OK : RESP_ERR;
        if ((awaddr_reg == OFF_CTRL) & wstrb_reg[0]) begin
          cl_reg  <= wdata_reg[3:0];
          x16_reg <= wdata_reg[4];
        end
      end
      if (bvalid_reg & I_BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path: data one cycle after the address is taken.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OK;
    end else if (I_ARVALID & arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (rvalid_reg & I_RREADY) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  assign O_AWREADY = awready_reg;
  assign O_WREADY  = wready_reg;
  assign O_BVALID  = bvalid_reg;
  assign O_BRESP   = bresp_reg;
  assign O_ARREADY = arready_reg;
  assign O_RVALID  = rvalid_reg;
  assign O_RDATA   = rdata_reg;
  assign O_RRESP   = rresp_reg;

  mr1_capture_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    set_mr1 |=> (mr1_reg == $past(addr))) else $error("register one not captured");
  mr2_capture_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    set_mr2 |=> (mr2_reg == $past(addr))) else $error("register two not captured");
  dll_sr_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    sr_entry |=> ##1 !O_DLL_ON) else $error("DLL stayed on in self-refresh");
  dll_sr_back_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sr_exit & !mr1_reg[M1_DLL_OFF] & !set_mr1) |=> ##1 O_DLL_ON) else $error("DLL not back after exit");
  lock_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (lock_run & cmd_rd) |=> err_reg[0]) else $error("early read not flagged");
  posted_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cmd_rd & (al_val == 4'h0)) |=> O_RD_ISSUE) else $error("read not issued at zero delay");
  read_sum_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (al_code == 2'h1) |-> (read_lat == 5'({cl_reg, 1'b0} - 5'h01))) else $error("read latency sum wrong");
  cwl_min_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (mr2_reg[5:3] == 3'h0) |-> (write_column_latency == 5'h05)) else $error("write column latency base wrong");
  partial_array_refresh_eighth_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (sr_reg & (partial_array_refresh == 3'h7)) |=> (O_BANK_RETAIN == 8'h80)) else $error("bank seven mask wrong");
  level_no_dyn_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    mr1_reg[M1_WLEVEL] |=> !O_TERM_WR_ON) else $error("write termination during leveling");
  out_off_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(mr1_reg[M1_OUT_OFF]) |=> O_OUT_DISABLE) else $error("outputs not disconnected");
endmodule
`default_nettype wire

// file: verification/dmr_ctrl_model.sv
// Purpose: Controller-side driver of the memory command and address pins.
// Assumes: Pins change by non-blocking assignment just after a rising edge.
// Notes:   Deselected pins carry inverted values so stale ones never decode.
`timescale 1ns/1ps
`default_nettype none
module dmr_ctrl_model
  import dmr_pkg::*;
(
  // Clock.
  input  wire logic   i_clk,
  // Command pins.
  output logic        o_cke,
  output logic        o_term,
  output logic        o_cs_n,
  output logic        o_ras_n,
  output logic        o_cas_n,
  output logic        o_we_n,
  output logic [2:0]  o_ba,
  output logic [13:0] o_a
);
  initial begin
    {o_cke, o_term, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_ba, o_a} = {6'h2F, 3'h0, 14'h0000};
  end
  // One command cycle, then a deselect with inverted pins.
  task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
    @(posedge i_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_ba, o_a} <= {c, ba, a};
    @(posedge i_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_ba, o_a} <= {1'b1, ~c[2:0], ~ba, ~a};
  endtask
  task automatic mode_set_command(input logic [2:0] ba, input logic [13:0] a);
    cmd(4'h0, ba, a);
    repeat (4) @(posedge i_clk);
  endtask
  // wait out lock with clock enable high.
  task automatic lock_wait();
    repeat (LOCK_WAIT_CYC + 10'h008) @(posedge i_clk);
  endtask
  task automatic sr_enter();
    @(posedge i_clk);
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 5'h01;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
  endtask
  task automatic sr_exit();
    @(posedge i_clk);
    o_cke <= 1'b1;
  endtask
  task automatic term(input logic v);
    @(posedge i_clk);
    o_term <= v;
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Purpose: Self-checking bench for the mode register decoder.
// Assumes: Bus tasks hold every request until its ready is sampled.
// Notes:   Expected figures come from the package constants and from literal values written into each test.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  import dmr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, keep;
  logic [31:0] wd = 32'h0, ld, rdata;
  logic [3:0]  ws = 4'h0;
  logic [1:0]  lr, bresp, rresp, drv;
  logic        awrdy, wrdy, bv, arrdy, rv, dll, odis, tstb, wlev, tnom, twr;
  logic        rdis, wris, sref, self_refresh_temp_range, auto_self_refresh, cke, term, cs_n, ras_n, cas_n, we_n, seen;
  logic [2:0]  ba;
  logic [13:0] a;
  logic [4:0]  al;
  logic [7:0]  keep_tbl [8] = '{8'hFF, 8'h0F, 8'h03, 8'h01, 8'hFC, 8'hF0, 8'hC0, 8'h80};
  int          error_cnt = 0;
  int          n_compared = 0;

  always #12.5 clk = ~clk;

  dmr_ctrl_model ctrl_u (.i_clk(clk), .o_cke(cke), .o_term(term), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_a(a));
  dmr_mode_regs dut_u (.I_CLK(clk), .I_RST(rst), .I_CKE(cke), .I_TERM(term), .I_CS_N(cs_n),
    .I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n), .I_BA(ba), .I_A(a),
    .I_AWVALID(awv), .O_AWREADY(awrdy), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy),
    .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp),
    .I_ARVALID(arv), .O_ARREADY(arrdy), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rr),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_DLL_ON(dll), .O_DRV_IMP(drv), .O_OUT_DISABLE(odis),
    .O_TERM_STROBE(tstb), .O_WR_LEVEL(wlev), .O_TERM_NOM_ON(tnom), .O_TERM_WR_ON(twr),
    .O_RD_ISSUE(rdis), .O_WR_ISSUE(wris), .O_SELF_REFRESH(sref), .O_SR_EXT_RANGE(self_refresh_temp_range),
    .O_AUTO_SR(auto_self_refresh), .O_BANK_RETAIN(keep));

  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {awv, awa, wv, wd, ws, br} <= {1'b1, ad, 1'b1, d, s, 1'b1};
    do begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!(br && bv));
    br <= 1'b0;
    lr = bresp;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    {arv, ara, rr} <= {1'b1, ad, 1'b1};
    do begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
    end while (!(rr && rv));
    rr <= 1'b0;
    {lr, ld} = {rresp, rdata};
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    `CHK("keep", 8'hFF, keep);
    rd(OFF_CTRL);
    `CHK("ctrl", {28'h0000000, RST_CL}, ld);
    rd(8'h40);
    `CHK("uresp", RESP_ERR, lr);
    `CHK("udata", 32'h00000000, ld);
  endtask
  task automatic t_mr1();
    ctrl_u.mode_set_command(BA_MR1, 14'h1002);
    #1;
    `CHK("off", 1'b1, odis);
    `CHK("drv", 2'h1, drv);
    `CHK("lvl", 1'b0, wlev);
    ctrl_u.mode_set_command(BA_MR2, 14'h0000);
    ctrl_u.mode_set_command(BA_MR1, 14'h0080);
    #1;
    `CHK("lvl1", 1'b1, wlev);
    `CHK("off0", 1'b0, odis);
    wr(OFF_MR1, 32'h00001000, 4'hF);
    rd(OFF_MR1);
    `CHK("mr1", 32'h00000080, ld);
  endtask
  // The read is issued inside the lock wait on purpose.
  task automatic t_lock();
    ctrl_u.mode_set_command(BA_MR0, 14'h0100);
    ctrl_u.cmd(4'h5, 3'h0, 14'h0000);
    settle();
    rd(OFF_STATUS);
    `CHK("early", 2'h2, {ld[8], ld[1]});
    ctrl_u.lock_wait();
    wr(OFF_STATUS, 32'h00000100, 4'h2);
    rd(OFF_STATUS);
    `CHK("lock", 2'h1, {ld[8], ld[1]});
  endtask
  task automatic issue(input logic [3:0] c, input int e);
    int n = 0;
    fork
      ctrl_u.cmd(c, 3'h0, 14'h0000);
      begin
        @(posedge clk);
        do begin
          @(posedge clk);
          #1;
          n++;
        end while (((c[0] ? rdis : wris) !== 1'b1) && n < 40);
      end
    join
    `CHK("dly", e, n);
  endtask
  task automatic t_lat();
    for (int c = 0; c < 3; c++) begin
      al = (c == 0) ? 5'h00 : 5'(RST_CL) - 5'(c);
      ctrl_u.mode_set_command(BA_MR1, 14'(c << M1_AL_LSB));
      ctrl_u.mode_set_command(BA_MR2, 14'h0018);
      rd(OFF_LAT);
      `CHK("lat", {19'h0, al + 5'h08, 3'h0, al + 5'h06}, ld);
      issue(4'h5, 3 + al);
      issue(4'h4, 3 + al);
    end
    for (int k = 0; k < 8; k++) begin
      ctrl_u.mode_set_command(BA_MR2, 14'(k << M2_CWL_LSB));
      rd(OFF_LAT);
      `CHK("wl", 5'(al + CWL_BASE + k), ld[12:8]);
    end
  endtask
  task automatic t_sr();
    for (int p = 0; p < 8; p++) begin
      // extended range asked with range bit or auto mode.
      ctrl_u.mode_set_command(BA_MR2, 14'(p | ((p & 1) << M2_ASR) | ((p & 2) << (M2_SRT - 1))));
      ctrl_u.sr_enter();
      repeat (6) @(posedge clk);
      #1;
      `CHK("sr", 1'b1, sref);
      `CHK("dll", 1'b0, dll);
      `CHK("keep", keep_tbl[p], keep);
      `CHK("srt", p[1], self_refresh_temp_range);
      `CHK("asr", p[0], auto_self_refresh);
      ctrl_u.sr_exit();
      repeat (6) @(posedge clk);
      #1;
      `CHK("dllx", 1'b1, dll);
      `CHK("keepx", 8'hFF, keep);
    end
    ctrl_u.lock_wait();
  endtask
  task automatic wterm(input logic e);
    seen = 1'b0;
    fork
      ctrl_u.cmd(4'h4, 3'h0, 14'h0000);
      repeat (40) begin
        @(posedge clk);
        #1;
        seen |= twr;
      end
    join
    `CHK("twr", e, seen);
  endtask
  task automatic t_term();
    ctrl_u.mode_set_command(BA_MR1, 14'h0004);
    ctrl_u.term(1'b1);
    settle();
    `CHK("nom", 1'b1, tnom);
    ctrl_u.mode_set_command(BA_MR1, 14'h0000);
    ctrl_u.mode_set_command(BA_MR2, 14'h0200);
    wterm(1'b1);
    ctrl_u.mode_set_command(BA_MR2, 14'h0400);
    wterm(1'b1);
    ctrl_u.mode_set_command(BA_MR1, 14'h0080);
    wterm(1'b0);
    ctrl_u.mode_set_command(BA_MR1, 14'h0001);
    wterm(1'b0);
    ctrl_u.mode_set_command(BA_MR1, 14'h0005);
    rd(OFF_STATUS);
    `CHK("dlloff", 2'h3, ld[11:10]);
    ctrl_u.mode_set_command(BA_MR1, 14'h0818);
    `CHK("strb", 1'b1, tstb);
    wr(OFF_CTRL, {27'h0, 1'b1, RST_CL}, 4'h1);
    settle();
    `CHK("strb16", 1'b0, tstb);
    rd(OFF_STATUS);
    `CHK("resv", 2'h3, ld[13:12]);
    // controller restores legal settings before clearing.
    wr(OFF_CTRL, {28'h0, RST_CL}, 4'h1);
    ctrl_u.mode_set_command(BA_MR1, 14'h0000);
    ctrl_u.mode_set_command(BA_MR2, 14'h0000);
    ctrl_u.term(1'b0);
    wr(OFF_STATUS, 32'h00003F00, 4'h2);
    rd(OFF_STATUS);
    `CHK("err", 6'h00, ld[13:8]);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mr1();
    t_lock();
    t_lat();
    t_sr();
    t_term();
    conclude();
  end
  // A stuck handshake ends the run as a failure.
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
